// ### test/rtca_regs_properties.sv
// assertion checker for the calendar clock register block
`include "rtca_consts.svh"
`timescale 1ns/100ps
module rtca_regs_properties #(
    parameter int HALF_CNT = `RTCA_HALF_CNT
) (
    input wire logic                    mclk,
    input wire logic                    rst_n,
    input wire logic                    sys_rst_n,
    input wire logic [`RTCA_ADDR_W-1:0] addr,
    input wire logic [31:0]             wr_data,
    input wire logic                    wr_en,
    input wire logic                    rd_en,
    input wire logic [31:0]             rd_data,
    input wire logic                    unlock_ok,
    input wire logic                    xtal_in,
    input wire logic                    cal_week_evt,
    input wire logic                    cal_month_evt,
    input wire logic                    cal_year_evt,
    input wire logic                    alarm_evt,
    input wire logic                    alarm_pulse,
    input wire logic                    clk_out,
    input wire logic                    clk_out_oe
);
    default clocking cb @(posedge mclk); endclocking
    // the other reset zeroes read data, so its cycles are left out
    default disable iff (!rst_n || !sys_rst_n);
    wire rd_con = rd_en && addr == 8'h00;
    wire rd_tim = rd_en && addr == 8'h20;
    wire rd_ali = rd_en && (addr[3:2] != 2'b00 || addr[7:4] > 4'h2);
    AST_ALIAS_READ_ZERO: assert property (rd_ali |=> rd_data == '0)
        else $error("alias or unmapped read not zero");
    AST_ALARM_UPPER_ZERO: assert property
        (rd_en && addr == 8'h10 |=> rd_data[31:16] == 16'h0000)
        else $error("alarm upper half not zero");
    AST_HOUR_TENS: assert property
        (rd_tim |=> rd_data[31:30] == 2'b00 && rd_data[29:28] != 2'b11)
        else $error("hours tens out of range");
    AST_MIN_TENS: assert property
        (rd_tim |=> !rd_data[23] && rd_data[23:20] <= 4'h5)
        else $error("minutes tens out of range");
    AST_SEC_LOW_ZERO: assert property
        (rd_tim |=> !rd_data[15] && rd_data[7:0] == 8'h00)
        else $error("seconds reserved bits not zero");
    AST_CON_RESERVED: assert property
        (rd_con |=> (rd_data & 32'hFC00_5F30) == '0)
        else $error("control reserved bits set");
    AST_SYNC_NEEDS_ON: assert property
        (rd_con |=> (!rd_data[2] || rd_data[15]) && rd_data[6] == rd_data[15])
        else $error("sync or clock status without module on");
    AST_OE_FOLLOWS_CON: assert property
        (rd_con |=> clk_out_oe == (rd_data[0] && rd_data[15]))
        else $error("output enable not on and enable bits");
    AST_EVT_ONE_CYCLE: assert property (alarm_evt |=> !alarm_evt)
        else $error("alarm event longer than one cycle");
    AST_HALF_CLEARED: assert property
        (wr_en && addr == 8'h20 ##2 rd_con |=> !rd_data[3] || !rd_data[1])
        else $error("half second flag kept after seconds write");
    cover property (alarm_evt);
    cover property (rd_con ##1 rd_data[2]);
    cover property (wr_en && addr[3:2] == 2'b11);
endmodule // rtca_regs_properties

bind rtca_regs rtca_regs_properties #(.HALF_CNT(HALF_CNT)) i_props (
    .mclk(mclk), .rst_n(rst_n), .sys_rst_n(sys_rst_n), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .unlock_ok(unlock_ok), .xtal_in(xtal_in), .cal_week_evt(cal_week_evt),
    .cal_month_evt(cal_month_evt), .cal_year_evt(cal_year_evt),
    .alarm_evt(alarm_evt), .alarm_pulse(alarm_pulse), .clk_out(clk_out),
    .clk_out_oe(clk_out_oe));

// ### test/testbench.sv
// self-checking bench for the calendar clock register block
`include "rtca_consts.svh"
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module testbench;
    import rtca_pkg::*;
    typedef struct {logic u; logic [7:0] wa; logic [31:0] wd;
                    logic [7:0] ra; logic [31:0] ex;} rtca_row_t;
    logic        mclk, rst_n, sys_rst_n, wr_en, rd_en, unlock_ok;
    logic        xtal_in, wk_evt, xrun, alarm_evt, alarm_pulse;
    logic        clk_out, clk_out_oe;
    logic [1:0]  xc;
    logic [7:0]  addr;
    logic [31:0] wr_data, rd_data, d, d2;
    int          miscompares, n_checks, n;
    rtca_row_t   rows [19] = '{
        '{0, 8'h08, 32'h0000_0008, 8'h00, 32'h0000_0000},
        '{1, 8'h08, 32'h0000_0008, 8'h00, 32'h0000_0008},
        '{0, 8'h08, 32'h0000_4076, 8'h00, 32'h0000_0008},
        '{0, 8'h08, 32'h0000_0001, 8'h00, 32'h0000_0009},
        '{0, 8'h0C, 32'h0000_0081, 8'h00, 32'h0000_0088},
        '{0, 8'h04, 32'hFFFF_FFF7, 8'h00, 32'h0000_0008},
        '{0, 8'h20, 32'h2359_5900, 8'h20, 32'h2359_5900},
        '{0, 8'h24, 32'h0000_0F00, 8'h20, 32'h2359_5000},
        '{0, 8'h2C, 32'h0000_0300, 8'h20, 32'h2359_5300},
        '{0, 8'h28, 32'hC000_00FF, 8'h20, 32'h2359_5300},
        '{0, 8'h10, 32'h0000_6F05, 8'h10, 32'h0000_6F05},
        '{0, 8'h14, 32'h0000_0F00, 8'h10, 32'h0000_6005},
        '{0, 8'h1C, 32'h0000_2003, 8'h10, 32'h0000_4006},
        '{0, 8'h18, 32'hFFFF_1000, 8'h10, 32'h0000_4006},
        '{0, 8'h14, 32'h0000_0000, 8'h1C, 32'h0000_0000},
        '{0, 8'h30, 32'h0000_0000, 8'h30, 32'h0000_0000},
        '{0, 8'h04, 32'h0000_0008, 8'h00, 32'h0000_0000},
        '{0, 8'h20, 32'h0000_0000, 8'h20, 32'h2359_5300},
        '{0, 8'h28, 32'h0000_0100, 8'h20, 32'h2359_5300}
    };

    rtca_regs #(.HALF_CNT(64)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .sys_rst_n(sys_rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .unlock_ok(unlock_ok), .xtal_in(xtal_in), .cal_week_evt(wk_evt),
        .cal_month_evt(1'b0), .cal_year_evt(1'b0), .alarm_evt(alarm_evt),
        .alarm_pulse(alarm_pulse), .clk_out(clk_out),
        .clk_out_oe(clk_out_oe));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // crystal stand-in: six clocks a period, slow enough for the synchroniser
    always @(posedge mclk) begin
        xc <= (xc == 2'd2) ? 2'd0 : xc + 2'd1;
        if (xrun && xc == 2'd0) xtal_in <= ~xtal_in;
    end

    task automatic finish_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 d = rd_data;
        @(posedge mclk);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(d & 32'hFFFF_DFFF, e)
    endtask
    // one week boundary, then a fixed window for the registered event
    task automatic evt(input logic e);
        logic seen;
        seen = 1'b0;
        wk_evt <= 1'b1;
        @(posedge mclk);
        wk_evt <= 1'b0;
        repeat (4) begin
            @(posedge mclk);
            if (alarm_evt === 1'b1) seen = 1'b1;
        end
        `CHK(seen, e)
    endtask

    initial begin
        {rst_n, wr_en, rd_en, unlock_ok, wk_evt, xrun, xtal_in} = '0;
        {addr, wr_data, xc} = '0;
        sys_rst_n = 1'b1;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        foreach (rows[i]) begin
            unlock_ok <= rows[i].u;
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra);
            `CHK(d, rows[i].ex)
        end
        $display("test registers done");
        unlock_ok <= 1'b1;
        wr(8'h08, 32'h0000_0009);
        sys_rst_n <= 1'b0;
        @(posedge mclk);
        sys_rst_n <= 1'b1;
        @(posedge mclk);
        chk_rd(8'h00, 32'h0000_0009);
        chk_rd(8'h10, 32'h0000_4006);
        rst_n <= 1'b0;
        @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk_rd(8'h00, 32'h0000_0000);
        chk_rd(8'h10, 32'h0000_0000);
        $display("test resets done");
        wr(8'h08, 32'h0000_0008);
        wr(8'h08, 32'h0000_8000);
        wr(8'h10, 32'h0000_8701);
        evt(1'b1);
        chk_rd(8'h10, 32'h0000_8700);
        `CHK(d[13], 1'b1)
        `CHK(alarm_pulse, 1'b1)
        `CHK(clk_out, 1'b1)
        evt(1'b1);
        chk_rd(8'h10, 32'h0000_0700);
        evt(1'b0);
        wr(8'h10, 32'h0000_C700);
        evt(1'b1);
        chk_rd(8'h10, 32'h0000_C7FF);
        evt(1'b1);
        chk_rd(8'h10, 32'h0000_C7FE);
        $display("test alarm count done");
        wr(8'h10, 32'h0000_8000);
        xrun <= 1'b1;
        n = 0;
        while (alarm_evt !== 1'b1 && n < 1000) begin
            @(posedge mclk);
            n++;
        end
        `CHK(n < 1000, 1'b1)
        if (n >= 1000) finish_test();
        xrun <= 1'b0;
        chk_rd(8'h10, 32'h0000_0000);
        d2 = d;
        chk_rd(8'h10, 32'h0000_0000);
        `CHK(d, d2)
        wr(8'h20, 32'h0000_0000);
        rd(8'h00);
        `CHK(d[1], 1'b0)
        $display("test half second done");
        finish_test();
    end
endmodule // testbench

// ### verilog/rtca_consts.svh
// constants for the calendar clock control, alarm and time registers
`ifndef RTCA_CONSTS_SVH
`define RTCA_CONSTS_SVH
`define RTCA_ADDR_W      8
`define RTCA_CON_BASE    4'h0
`define RTCA_ALRM_BASE   4'h1
`define RTCA_TIME_BASE   4'h2
`define RTCA_ZERO        32'h0000_0000
`define RTCA_CON_WMASK   32'h03FF_A089
`define RTCA_CON_ON      15
`define RTCA_CON_WREN    3
`define RTCA_CON_SYNC    2
`define RTCA_CON_HALF    1
`define RTCA_CON_CLKON   6
`define RTCA_CON_SECSEL  7
`define RTCA_CON_OE      0
`define RTCA_ALRM_WMASK  32'h0000_EFFF
`define RTCA_AL_EN       15
`define RTCA_AL_CHIME    14
`define RTCA_AL_PIV      13
`define RTCA_AL_SYNC     12
`define RTCA_AL_SEL_HI   11
`define RTCA_AL_SEL_LO   8
`define RTCA_AL_RPT_HI   7
`define RTCA_AL_RPT_LO   0
`define RTCA_TIME_WMASK  32'h3F7F_7F00
`define RTCA_SEC_MASK    32'h0000_FF00
`define RTCA_HALF_CNT    16384
`define RTCA_SYNC_WIN    32
`define RTCA_BCD_NINE    4'h9
`define RTCA_BCD_FIVE    4'h5
`define RTCA_HR_TENS_MAX 4'h2
`define RTCA_HR_UNIT_MAX 4'h3
`define RTCA_DIGIT_ZERO  4'h0
`endif

// ### verilog/rtca_pkg.sv
// types for the calendar clock register block
package rtca_pkg;
    typedef enum logic [1:0] {
        RTCA_OP_WRITE = 2'b00,
        RTCA_OP_CLR   = 2'b01,
        RTCA_OP_SET   = 2'b10,
        RTCA_OP_INV   = 2'b11
    } rtca_op_t;
    typedef enum logic [3:0] {
        RTCA_IV_HALF  = 4'b0000,
        RTCA_IV_SEC   = 4'b0001,
        RTCA_IV_SECONDS_TENS = 4'b0010,
        RTCA_IV_MIN   = 4'b0011,
        RTCA_IV_MINUTES_TENS = 4'b0100,
        RTCA_IV_HOUR  = 4'b0101,
        RTCA_IV_DAY   = 4'b0110,
        RTCA_IV_WEEK  = 4'b0111,
        RTCA_IV_MONTH = 4'b1000,
        RTCA_IV_YEAR  = 4'b1001
    } rtca_interval_t;
endpackage

// ### verilog/rtca_regs.sv
// control, alarm control and time value registers of the calendar clock
//
// Implementation choices: strobed register access and the address map.
`include "rtca_consts.svh"
`timescale 1ns/100ps
module rtca_regs #(
    parameter int HALF_CNT = `RTCA_HALF_CNT
) (
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic                    sys_rst_n,
    input  wire logic [`RTCA_ADDR_W-1:0] addr,
    input  wire logic [31:0]             wr_data,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    output logic      [31:0]             rd_data,
    input  wire logic                    unlock_ok,
    input  wire logic                    xtal_in,
    input  wire logic                    cal_week_evt,
    input  wire logic                    cal_month_evt,
    input  wire logic                    cal_year_evt,
    output logic                         alarm_evt,
    output logic                         alarm_pulse,
    output logic                         clk_out,
    output logic                         clk_out_oe
);
    import rtca_pkg::*;

    localparam int CW = $clog2(HALF_CNT);

    logic [31:0]   con_q;
    logic [31:0]   con_d;
    logic [31:0]   alrm_q;
    logic [31:0]   alrm_d;
    logic [31:0]   time_q;
    logic [31:0]   time_d;
    logic [31:0]   rd_q;
    logic [CW-1:0] pre_q;
    logic [2:0]    xs_q;
    logic          pulse_q;
    logic          evt_q;
    logic          half_q;
    logic          out_q;
    logic          oe_q;
    logic          xtick;
    logic          half_tick;
    logic          sec_tick;
    logic          near_roll;
    logic          sel_con;
    logic          sel_alrm;
    logic          sel_time;
    rtca_op_t      op;
    logic [9:0]    ev_vec;
    logic          al_hit;
    logic [3:0]    su;
    logic [3:0]    st;
    logic [3:0]    mu;
    logic [3:0]    mt;
    logic [3:0]    hu;
    logic [3:0]    ht;
    logic          w_su;
    logic          w_st;
    logic          w_mu;
    logic          w_mt;
    logic          w_hr;

    // masked update shared by the three registers and their aliases
    function automatic logic [31:0] alias_upd(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [31:0] mask,
        input rtca_op_t    kind
    );
        logic [31:0] v;
        v = wd;
        unique case (kind)
            RTCA_OP_WRITE: v = wd;
            RTCA_OP_CLR:   v = old & ~wd;
            RTCA_OP_SET:   v = old | wd;
            RTCA_OP_INV:   v = old ^ wd;
        endcase
        return (old & ~mask) | (v & mask);
    endfunction

    // crystal pin: two flops, then the edge detector reads the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xs_q <= 3'h0;
        end else begin
            xs_q <= {xs_q[1:0], xtal_in};
        end
    end
    assign xtick = xs_q[1] & ~xs_q[2];

    assign half_tick = xtick && con_q[`RTCA_CON_ON] &&
                       (pre_q == CW'(HALF_CNT - 1));
    assign sec_tick  = half_tick && half_q;
    // a cpu read fits well inside the window, so one compare suffices
    assign near_roll = con_q[`RTCA_CON_ON] &&
                       (pre_q >= CW'(HALF_CNT - `RTCA_SYNC_WIN));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
        end else if (!con_q[`RTCA_CON_ON]) begin
            pre_q <= '0;
        end else if (xtick) begin
            if (pre_q == CW'(HALF_CNT - 1)) begin
                pre_q <= '0;
            end else begin
                pre_q <= pre_q + CW'(1);
            end
        end
    end

    assign sel_con  = addr[7:4] == `RTCA_CON_BASE;
    assign sel_alrm = addr[7:4] == `RTCA_ALRM_BASE;
    assign sel_time = addr[7:4] == `RTCA_TIME_BASE;
    assign op       = rtca_op_t'(addr[3:2]);

    assign su = time_q[11:8];
    assign st = time_q[15:12];
    assign mu = time_q[19:16];
    assign mt = time_q[23:20];
    assign hu = time_q[27:24];
    assign ht = time_q[31:28];
    assign w_su = sec_tick && su == `RTCA_BCD_NINE;
    assign w_st = w_su && st == `RTCA_BCD_FIVE;
    assign w_mu = w_st && mu == `RTCA_BCD_NINE;
    assign w_mt = w_mu && mt == `RTCA_BCD_FIVE;
    assign w_hr = w_mt && ht == `RTCA_HR_TENS_MAX &&
                  hu == `RTCA_HR_UNIT_MAX;

    // calendar events fire only on dates that exist, so a february 29
    // yearly alarm recurs only in leap years
    assign ev_vec = {cal_year_evt, cal_month_evt, cal_week_evt,
                     w_hr, w_mt, w_mu, w_st, w_su, sec_tick, half_tick};

    always_comb begin
        unique case (alrm_q[`RTCA_AL_SEL_HI:`RTCA_AL_SEL_LO])
            RTCA_IV_HALF:  al_hit = ev_vec[0];
            RTCA_IV_SEC:   al_hit = ev_vec[1];
            RTCA_IV_SECONDS_TENS: al_hit = ev_vec[2];
            RTCA_IV_MIN:   al_hit = ev_vec[3];
            RTCA_IV_MINUTES_TENS: al_hit = ev_vec[4];
            RTCA_IV_HOUR:  al_hit = ev_vec[5];
            RTCA_IV_DAY:   al_hit = ev_vec[6];
            RTCA_IV_WEEK:  al_hit = ev_vec[7];
            RTCA_IV_MONTH: al_hit = ev_vec[8];
            RTCA_IV_YEAR:  al_hit = ev_vec[9];
            default:       al_hit = 1'b0;
        endcase
        al_hit = al_hit && alrm_q[`RTCA_AL_EN];
    end

    // control register: software write, then hardware status bits
    always_comb begin
        logic [31:0] m;
        m = `RTCA_CON_WMASK;
        if (!con_q[`RTCA_CON_WREN]) begin
            m[`RTCA_CON_ON] = 1'b0;
        end
        con_d = con_q;
        if (wr_en && sel_con) begin
            con_d = alias_upd(con_q, wr_data, m, op);
            if (!unlock_ok && !con_q[`RTCA_CON_WREN]) begin
                con_d[`RTCA_CON_WREN] = 1'b0;
            end
        end
        con_d[`RTCA_CON_SYNC]  = near_roll;
        con_d[`RTCA_CON_HALF]  = half_q;
        con_d[`RTCA_CON_CLKON] = con_q[`RTCA_CON_ON];
    end

    // power-on reset only; the system reset leaves it alone
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            con_q <= `RTCA_ZERO;
        end else begin
            con_q <= con_d;
        end
    end

    // alarm: the write and the event are merged in one cycle so an
    // event landing on a software write is not lost
    always_comb begin
        logic [31:0] m;
        logic [7:0]  rpt;
        m = `RTCA_ALRM_WMASK;
        if (alrm_q[`RTCA_AL_EN]) begin
            m[`RTCA_AL_PIV] = 1'b0;
        end
        alrm_d = alrm_q;
        if (wr_en && sel_alrm) begin
            alrm_d = alias_upd(alrm_q, wr_data, m, op);
        end
        rpt = alrm_d[`RTCA_AL_RPT_HI:`RTCA_AL_RPT_LO];
        if (al_hit) begin
            if (rpt == 8'h00 && !alrm_d[`RTCA_AL_CHIME]) begin
                alrm_d[`RTCA_AL_EN] = 1'b0;
            end else begin
                rpt = rpt - 8'h01;
            end
        end
        alrm_d[`RTCA_AL_RPT_HI:`RTCA_AL_RPT_LO] = rpt;
        alrm_d[`RTCA_AL_SYNC] = near_roll;
        if (alrm_d[`RTCA_AL_EN] && alrm_q[`RTCA_AL_EN]) begin
            alrm_d[`RTCA_AL_PIV] = pulse_q ^ al_hit;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alrm_q <= `RTCA_ZERO;
        end else begin
            alrm_q <= alrm_d;
        end
    end

    // pulse starts from the initial value and toggles per event
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= 1'b0;
        end else if (!alrm_q[`RTCA_AL_EN]) begin
            pulse_q <= alrm_d[`RTCA_AL_PIV];
        end else if (al_hit) begin
            pulse_q <= ~pulse_q;
        end
    end

    // time: the counting happens before a software write in the same
    // cycle, so the written value wins and no tick corrupts it
    always_comb begin
        time_d = time_q;
        if (sec_tick) begin
            time_d[11:8] = w_su ? `RTCA_DIGIT_ZERO : su + 4'h1;
            if (w_su) begin
                time_d[15:12] = w_st ? `RTCA_DIGIT_ZERO : st + 4'h1;
            end
            if (w_st) begin
                time_d[19:16] = w_mu ? `RTCA_DIGIT_ZERO : mu + 4'h1;
            end
            if (w_mu) begin
                time_d[23:20] = w_mt ? `RTCA_DIGIT_ZERO : mt + 4'h1;
            end
            if (w_hr) begin
                time_d[31:24] = {`RTCA_DIGIT_ZERO, `RTCA_DIGIT_ZERO};
            end else if (w_mt) begin
                if (hu == `RTCA_BCD_NINE) begin
                    time_d[27:24] = `RTCA_DIGIT_ZERO;
                    time_d[31:28] = ht + 4'h1;
                end else begin
                    time_d[27:24] = hu + 4'h1;
                end
            end
        end
        if (wr_en && sel_time && con_q[`RTCA_CON_WREN]) begin
            time_d = alias_upd(time_d, wr_data, `RTCA_TIME_WMASK, op);
        end
    end

    // bits 7:0 and the top tens bits never load: the write mask keeps
    // them zero, so a read needs no extra masking
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            time_q <= `RTCA_ZERO;
        end else begin
            time_q <= time_d;
        end
    end

    // half second flag; a seconds write clears it even on a tick
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            half_q <= 1'b0;
        end else if (wr_en && sel_time && con_q[`RTCA_CON_WREN] &&
                     (op == RTCA_OP_WRITE ||
                      (wr_data & `RTCA_SEC_MASK) != `RTCA_ZERO)) begin
            half_q <= 1'b0;
        end else if (half_tick) begin
            half_q <= ~half_q;
        end
    end

    // read data one cycle after the strobe; aliases and holes read zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= `RTCA_ZERO;
        end else if (!sys_rst_n) begin
            rd_q <= `RTCA_ZERO;
        end else if (rd_en && op == RTCA_OP_WRITE) begin
            unique case (addr[7:4])
                `RTCA_CON_BASE:  rd_q <= con_q;
                `RTCA_ALRM_BASE: rd_q <= alrm_q;
                `RTCA_TIME_BASE: rd_q <= time_q;
                default:         rd_q <= `RTCA_ZERO;
            endcase
        end else begin
            rd_q <= `RTCA_ZERO;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            evt_q <= 1'b0;
            out_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            evt_q <= al_hit;
            out_q <= con_q[`RTCA_CON_SECSEL] ? half_q : pulse_q;
            oe_q  <= con_q[`RTCA_CON_OE] & con_q[`RTCA_CON_ON];
        end
    end

    assign rd_data     = rd_q;
    assign alarm_evt   = evt_q;
    assign alarm_pulse = pulse_q;
    assign clk_out     = out_q;
    assign clk_out_oe  = oe_q;
endmodule // rtca_regs
